/* core/ddc_link_defs.vh */
// constants for the down-converter link transmit block
`ifndef DDC_LINK_DEFS_VH
`define DDC_LINK_DEFS_VH
`define DEC_BYPASS 3'h0
`define DEC_BY4 3'h1
`define DEC_BY8 3'h2
`define DEC_BY16 3'h3
`define DEC_BY32 3'h4
`define LOG2_BY4 3'h2
`define LOG2_BY32 3'h5
`define MAX_LANES 5'h10
`define LANE_CNT_W 5
`define CODE_8B10B 1'b0
`define CODE_64B66B 1'b1
`define ILAS_MULTIFRAMES 3'h4
`define SAMPLE_W 16
`define FIFO_DEPTH 8
`define K28_5 8'hBC
`define K28_0 8'h1C
`define K28_3 8'h7C
`define SH_DATA 2'h1
`define SCR_SEED 15'h7FFF
`endif

/* core/sample_fifo.v */
// parameterised valid/ready FIFO for the sample path
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire nrst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doWr;
  wire doRd;
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign outData = mem[rdPtr];
  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      case ({doWr, doRd})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule

/* core/ddc_serial_link_transmit.v */
// down-converter decimation/boost and serial link framing, transmit side
// Contract
// R1: decimation chosen only by link mode select
// R2: bypass real samples, decimated ones complex
// R3: boost one gives 6.02 dB chain gain
// R4: boost zero gives unity chain gain
// R5: host enables boost only when image filtered
// R6: output spread over up to sixteen lanes
// R7: lanes support 8B/10B and 64B/66B coding
// R8: 64B/66B block sync uses sync header
// R9: receiver drives handshake low to start sync
// R10: 64B/66B ignores handshake except oscillator sync
// R11: all logic runs from device clock
// R12: reference event resets multiframe/multiblock counter
// R13: forward error correction in 64B/66B coding
// R14: no 64B/80B, command channel or CRC3
// R15: subclass 1 transmitter, no subclass 2
// R16: alignment within one link only
// R17: physical handshake pin in 8B/10B coding
// R18: handshake timing compatible with older revisions
// R19: commas on all lanes while handshake low
// R20: after rise, wait edge, send four-multiframe alignment
// R21: scrambling optional 8B/10B, forced in 64B/66B
`timescale 1ns/100ps
`include "ddc_link_defs.vh"
module ddc_serial_link_transmit (
  input wire clk,
  input wire nrst,
  input wire [2:0] linkModeSelect,
  input wire lineCode,
  input wire gainBoost,
  input wire scrambleEnable,
  input wire fecEnable,
  input wire ncoSyncOnHandshake,
  input wire [`LANE_CNT_W-1:0] laneCount,
  input wire [7:0] framesPerMultiframe,
  input wire handshakeN,
  input wire sysref,
  input wire sampleValid,
  output wire sampleReady,
  input wire [`SAMPLE_W-1:0] sampleData,
  output reg [`SAMPLE_W-1:0] laneData,
  output reg [1:0] laneSyncHeader,
  output reg laneIsControl,
  output reg [`LANE_CNT_W-1:0] laneIndex,
  output reg laneValid,
  output reg sampleComplex,
  output reg ncoSync,
  output reg fecActive,
  output reg linkUp
);
  localparam ST_CGS = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ILAS = 2'h2;
  localparam ST_DATA = 2'h3;
  reg [1:0] state;
  reg [1:0] next_state;
  reg syncMeta;
  reg syncPin;
  reg syncLast;
  reg refMeta;
  reg refPin;
  reg refLast;
  reg [7:0] frameCnt;
  reg [2:0] ilasCnt;
  reg [2:0] decSel;
  reg [2:0] decPhase;
  reg [14:0] lfsr;
  wire refEdge;
  wire mfEdge;
  wire fifoValid;
  wire [`SAMPLE_W-1:0] fifoData;
  wire fifoTake;
  wire [`SAMPLE_W-1:0] gained;
  wire scrOn;
  wire [2:0] decLog;
  // log2 of the decimation factor from a selector code
  function [2:0] dec_log2;
    input [2:0] sel;
    begin
      case (sel)
        `DEC_BY4: dec_log2 = `LOG2_BY4;
        `DEC_BY8: dec_log2 = 3'h3;
        `DEC_BY16: dec_log2 = 3'h4;
        `DEC_BY32: dec_log2 = `LOG2_BY32;
        default: dec_log2 = 3'h0;
      endcase
    end
  endfunction
  // saturating double for the boosted path
  function [`SAMPLE_W-1:0] sat_double;
    input [`SAMPLE_W-1:0] v;
    begin
      if (v[15] != v[14]) begin
        sat_double = v[15] ? 16'h8000 : 16'h7FFF;
      end else begin
        sat_double = {v[14:0], 1'b0};
      end
    end
  endfunction
  // pin inputs pass two flops
  always @(posedge clk) begin
    if (!nrst) begin
      syncMeta <= 1'b1;
      syncPin <= 1'b1;
      syncLast <= 1'b1;
      refMeta <= 1'b0;
      refPin <= 1'b0;
      refLast <= 1'b0;
    end else begin
      syncMeta <= handshakeN; // R17
      syncPin <= syncMeta; // R18
      syncLast <= syncPin;
      refMeta <= sysref;
      refPin <= refMeta;
      refLast <= refPin;
    end
  end
  assign refEdge = refPin && !refLast;
  // multiframe / extended multiblock counter on device clock
  always @(posedge clk) begin
    if (!nrst) begin
      frameCnt <= 8'h00;
    end else if (refEdge) begin
      frameCnt <= 8'h00; // R12 R15
    end else if (frameCnt == framesPerMultiframe) begin
      frameCnt <= 8'h00;
    end else begin
      frameCnt <= frameCnt + 8'h01; // R11
    end
  end
  assign mfEdge = (frameCnt == 8'h00);
  // decimation selected only from mode select
  always @(posedge clk) begin
    if (!nrst) begin
      decSel <= `DEC_BYPASS;
      sampleComplex <= 1'b0;
      fecActive <= 1'b0;
      ncoSync <= 1'b0;
    end else begin
      decSel <= (linkModeSelect > `DEC_BY32) ? `DEC_BYPASS : linkModeSelect; // R1
      sampleComplex <= (decSel != `DEC_BYPASS); // R2
      fecActive <= (lineCode == `CODE_64B66B) && fecEnable; // R13 R14
      ncoSync <= (lineCode == `CODE_64B66B) && ncoSyncOnHandshake && !syncPin; // R10
    end
  end
  assign decLog = dec_log2(decSel);
  assign gained = gainBoost ? sat_double(fifoData) : fifoData; // R3 R4 R5
  assign scrOn = (lineCode == `CODE_64B66B) || scrambleEnable; // R21
  // link state machine
  always @* begin
    next_state = state;
    case (state)
      ST_CGS: begin
        if (lineCode == `CODE_64B66B) begin
          next_state = ST_DATA; // R8 R10
        end else if (syncPin && !syncLast) begin
          next_state = ST_WAIT; // R20
        end
      end
      ST_WAIT: begin
        if (!syncPin) begin
          next_state = ST_CGS;
        end else if (mfEdge) begin
          next_state = ST_ILAS; // R20
        end
      end
      ST_ILAS: begin
        if (!syncPin) begin
          next_state = ST_CGS;
        end else if (mfEdge && ilasCnt == `ILAS_MULTIFRAMES - 3'h1) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (lineCode == `CODE_8B10B && !syncPin) begin
          next_state = ST_CGS; // R9
        end
      end
      default: next_state = ST_CGS;
    endcase
  end
  always @(posedge clk) begin
    if (!nrst) begin
      state <= ST_CGS;
      ilasCnt <= 3'h0;
    end else begin
      state <= next_state;
      if (state != ST_ILAS) begin
        ilasCnt <= 3'h0;
      end else if (mfEdge) begin
        ilasCnt <= ilasCnt + 3'h1; // R20
      end
    end
  end
  // decimation phase: one output sample per 2^(log-2) input samples, every sample in bypass
  assign fifoTake = fifoValid && (state == ST_DATA);
  always @(posedge clk) begin
    if (!nrst) begin
      decPhase <= 3'h0;
    end else if (fifoTake) begin
      decPhase <= decPhase + 3'h1;
    end
  end
  // lane output framing, lanes served round robin
  always @(posedge clk) begin
    if (!nrst) begin
      laneData <= 16'h0000;
      laneSyncHeader <= 2'h0;
      laneIsControl <= 1'b0;
      laneIndex <= {`LANE_CNT_W{1'b0}};
      laneValid <= 1'b0;
      linkUp <= 1'b0;
      lfsr <= `SCR_SEED;
    end else begin
      linkUp <= (state == ST_DATA);
      laneSyncHeader <= (lineCode == `CODE_64B66B) ? `SH_DATA : 2'h0; // R8 R7
      if (laneIndex >= laneCount - 1'b1 || laneIndex == `MAX_LANES - 1'b1) begin
        laneIndex <= {`LANE_CNT_W{1'b0}}; // R6 R16
      end else begin
        laneIndex <= laneIndex + 1'b1;
      end
      case (state)
        ST_CGS, ST_WAIT: begin
          laneValid <= (lineCode == `CODE_8B10B);
          laneIsControl <= (lineCode == `CODE_8B10B); // R8
          laneData <= {`K28_5, `K28_5}; // R19
        end
        ST_ILAS: begin
          laneValid <= 1'b1;
          laneIsControl <= mfEdge || frameCnt == framesPerMultiframe;
          if (mfEdge) begin
            laneData <= {`K28_0, 8'h00};
          end else if (frameCnt == framesPerMultiframe) begin
            laneData <= {8'h00, `K28_3};
          end else begin
            laneData <= {5'h00, ilasCnt, frameCnt}; // alignment data, never scrambled
          end
        end
        default: begin
          laneIsControl <= 1'b0;
          laneValid <= fifoTake && (decLog == 3'h0 || (decPhase & ((3'h1 << (decLog - 3'h2))
            - 3'h1)) == 3'h0);
          if (fifoTake) begin
            lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
            laneData <= scrOn ? (gained ^ {lfsr, lfsr[0]}) : gained; // R21
          end
        end
      endcase
    end
  end
  sample_fifo #(
    .WIDTH(`SAMPLE_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(fifoValid),
    .outReady(state == ST_DATA),
    .outData(fifoData)
  );
endmodule

/* dv/ddc_link_checker_properties.sv */
// port assertions for the link transmit block
`timescale 1ns/100ps
module ddc_link_checker (
  input wire clk,
  input wire nrst,
  input wire [2:0] linkModeSelect,
  input wire lineCode,
  input wire fecEnable,
  input wire ncoSyncOnHandshake,
  input wire [4:0] laneCount,
  input wire handshakeN,
  input wire [15:0] laneData,
  input wire [1:0] laneSyncHeader,
  input wire laneIsControl,
  input wire [4:0] laneIndex,
  input wire laneValid,
  input wire sampleComplex,
  input wire ncoSync,
  input wire fecActive,
  input wire linkUp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_complex_mode: assert property (
    $past(nrst) && $past(nrst, 2) |->
    sampleComplex == ($past(linkModeSelect, 2) inside {[3'h1:3'h4]}))
    else $error("complex flag wrong");
  a_sync_header: assert property (
    $past(nrst) |-> laneSyncHeader == ($past(lineCode) ? 2'h1 : 2'h0))
    else $error("sync header wrong");
  a_fec_only66: assert property (
    $past(nrst) |-> fecActive == ($past(lineCode) && $past(fecEnable)))
    else $error("fec flag wrong");
  a_nco_quiet8: assert property (
    $past(nrst) && !$past(lineCode) |-> !ncoSync) else $error("nco sync in 8b mode");
  a_no_ctrl66: assert property (
    $past(nrst) && $past(lineCode) |-> !laneIsControl) else $error("control word in 66b");
  a_comma_fill: assert property (
    (!lineCode && !handshakeN) [*4] |=> laneIsControl && laneData == 16'hBCBC)
    else $error("no comma while handshake low");
  a_down_on_low: assert property (
    (!lineCode && !handshakeN) [*4] |=> !linkUp) else $error("link up while handshake low");
  a_lane_range: assert property (
    laneValid |-> laneIndex < laneCount) else $error("lane index out of range");
endmodule

/* dv/link_receiver_model.sv */
// receiver-side model: handshake and reference pulse
`timescale 1ns/100ps
module link_receiver_model (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [15:0] laneData,
  input wire laneIsControl,
  output logic handshakeN = 1'b1,
  output logic sysref = 1'b0
);
  logic armed = 1'b1;
  int commas = 0;
  always @(posedge clk) begin
    sysref <= nrst && start && armed;
    if (!nrst || !start) begin
      handshakeN <= 1'b1;
      armed <= 1'b1;
      commas <= 0;
    end else if (armed) begin
      handshakeN <= 1'b0;
      armed <= 1'b0;
    end else if (!handshakeN) begin
      commas <= (laneIsControl && laneData == 16'hBCBC) ? commas + 1 : 0;
      if (commas == 4) handshakeN <= 1'b1;
    end
  end
endmodule

/* dv/tb_top.sv */
// testbench for the link transmit block
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, nrst = 0, lineCode = 0, gainBoost = 0, fecEnable = 0;
  logic start = 0, sampleValid = 0, seenStart = 0;
  logic [2:0] linkModeSelect = 3'h0;
  logic [15:0] sampleData = 16'h0000;
  wire handshakeN, sysref, sampleReady, laneIsControl, laneValid;
  wire sampleComplex, ncoSync, fecActive, linkUp;
  wire [15:0] laneData;
  wire [1:0] laneSyncHeader;
  wire [4:0] laneIndex;
  int num_errors = 0, n_tests = 0, lanes = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (laneIsControl && laneData == 16'h1C00) seenStart <= 1'b1;
    if (laneValid === 1'b1) lanes <= lanes + 1;
  end
  ddc_serial_link_transmit DUT (.clk, .nrst, .linkModeSelect, .lineCode, .gainBoost,
    .scrambleEnable(1'b0), .fecEnable, .ncoSyncOnHandshake(1'b1), .laneCount(5'h04),
    .framesPerMultiframe(8'h03), .handshakeN, .sysref, .sampleValid, .sampleReady,
    .sampleData, .laneData, .laneSyncHeader, .laneIsControl, .laneIndex, .laneValid,
    .sampleComplex, .ncoSync, .fecActive, .linkUp);
  link_receiver_model RX (.clk, .nrst, .start, .laneData, .laneIsControl, .handshakeN, .sysref);
  task check(input string name, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task do_reset(input logic code);
    nrst <= 1'b0;
    lineCode <= code;
    fecEnable <= code;
    start <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task push(input logic [15:0] v);
    sampleValid <= 1'b1;
    sampleData <= v;
    @(negedge clk);
    while (sampleReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask
  task wait_lane;
    for (int i = 0; i < 50 && laneValid !== 1'b1; i++) @(negedge clk);
  endtask
  task t_fifo;
    int n;
    n = 0;
    sampleValid <= 1'b1;
    repeat (12) begin
      @(negedge clk);
      if (sampleReady === 1'b1) n++;
      @(posedge clk);
    end
    sampleValid <= 1'b0;
    check("fifo words", n[15:0], 16'h0008);
  endtask
  task t_link8;
    start <= 1'b1;
    for (int i = 0; i < 2000 && linkUp !== 1'b1; i++) @(negedge clk);
    check("link up", linkUp, 16'h0001);
    check("alignment start", seenStart, 16'h0001);
    check("handshake", handshakeN, 16'h0001);
  endtask
  task one(input logic [2:0] m, input logic b, input logic [15:0] v, exp);
    linkModeSelect <= m;
    gainBoost <= b;
    push(v);
    wait_lane;
    check("lane data", laneData, exp);
    check("complex", sampleComplex, {15'h0000, m != 3'h0});
    @(posedge clk);
  endtask
  task t_decim;
    int base, n;
    gainBoost <= 1'b0;
    for (int m = 0; m < 6; m++) begin
      linkModeSelect <= m[2:0];
      n = (m == 0 || m == 5) ? 2 : 2 << (m - 1);
      repeat (20) @(posedge clk);
      base = lanes;
      repeat (n) begin
        push(16'h0101);
        @(posedge clk);
      end
      repeat (20) @(posedge clk);
      check("decimated count", lanes - base, 16'h0002);
      check("complex mode", sampleComplex, {15'h0000, m > 0 && m < 5});
    end
  endtask
  task t_66;
    do_reset(1'b1);
    for (int i = 0; i < 20 && linkUp !== 1'b1; i++) @(negedge clk);
    check("link up 66", linkUp, 16'h0001);
    check("sync header", laneSyncHeader, 16'h0001);
    check("fec", fecActive, 16'h0001);
    @(posedge clk);
    push(16'h0000);
    wait_lane;
    check("scrambled", laneData == 16'h0000, 16'h0000);
  endtask
  initial begin
    do_reset(1'b0);
    t_fifo;
    t_link8;
    repeat (40) @(posedge clk);
    one(3'h0, 1'b0, 16'h1234, 16'h1234);
    one(3'h1, 1'b1, 16'h1234, 16'h2468);
    one(3'h1, 1'b1, 16'h5000, 16'h7FFF);
    t_decim;
    t_66;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule
bind ddc_serial_link_transmit ddc_link_checker CHK (.clk, .nrst, .linkModeSelect, .lineCode,
  .fecEnable, .ncoSyncOnHandshake, .laneCount, .handshakeN, .laneData, .laneSyncHeader,
  .laneIsControl, .laneIndex, .laneValid, .sampleComplex, .ncoSync, .fecActive, .linkUp);
